/* File: dspma_fabric.sv */
// model of the fabric logic and the preceding block that feed the half block
`timescale 1ns/1ps
module dspma_fabric import dspma_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	output dspma_opnd_s [NMUL-1:0] opnd,
	output dspma_dyn_s dyn,
	output logic [S2W-1:0] chain_in
);
	logic [S2W-1:0] chain_src;

	initial begin
		opnd = '0;
		dyn = '0;
		chain_src = '0;
	end

	// a single sign pair serves every operand of the half block
	task automatic ctl(input logic sa, input logic sb, input logic rnd, input logic sat,
		input logic [S2W-1:0] ch);
		dyn <= '{sign_a: sa, sign_b: sb, round: rnd, saturate: sat, acc_sload: 1'b0};
		chain_src <= ch;
	endtask

	// accumulator load control, changed alone so dyn sees one write per step
	task automatic acc(input logic ld);
		dyn.acc_sload <= ld;
	endtask

	task automatic ops(input int k, input logic [DW-1:0] av, input logic [DW-1:0] bv);
		opnd[k] <= '{a: av, b: bv};
	endtask

	// cascade input is the value last passed to ctl, delayed by one register stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			chain_in <= '0;
		else
			chain_in <= chain_src;
	end
endmodule

/* File: dspma_half.sv */
// multiply-add half block: four multipliers, adders, round/sat, output banks
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module dspma_half import dspma_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NGRP-1:0] clk_ena,
	input wire logic [NGRP-1:0] aclr,
	input wire dspma_opnd_s [NMUL-1:0] opnd,
	input wire dspma_dyn_s dyn,
	input wire dspma_osel_e osel_dyn,
	input wire logic [S2W-1:0] chain_in,
	output logic [S2W-1:0] chain_out,
	output logic [RW-1:0] result,
	output logic sat_ovf
);

	logic [CTRL_W-1:0] ctrl_r;
	logic [RSAT_W-1:0] rsat_r;
	dspma_cfg_s cfg;
	logic [NGRP-1:0] grst_n;
	logic hit;
	logic sa_r;
	logic sb_r;
	logic sa;
	logic sb;
	dspma_opnd_s [NMUL-1:0] op_r;
	dspma_opnd_s [NMUL-1:0] op;
	logic wide;
	logic [4:0] mwa;
	logic [4:0] mwb;
	logic [NMUL-1:0] msa;
	logic [NMUL-1:0] msb;
	logic [PW-1:0] prod [NMUL];
	logic [NMUL-1:0] psgn;
	logic [S1W-1:0] s1 [2];
	logic [PW-1:0] pp_r [NMUL];
	logic [S1W-1:0] s1_r [2];
	logic [PW-1:0] pq [NMUL];
	logic [S1W-1:0] s1q [2];
	logic [RW-1:0] m72;
	logic [S2W-1:0] s2;
	logic [S2W-1:0] s2a_r;
	logic [S2W-1:0] csum;
	logic [S2W-1:0] rs_in;
	logic [S2W-1:0] rs_y;
	logic rs_ovf;
	logic rs_ok;
	dspma_osel_e osel;
	logic [S2W-1:0] omux;
	logic [S2W-1:0] ob_c;
	logic [S2W-1:0] ob_r;
	logic [S2W-1:0] ob_q;
	logic [S2W-1:0] lo_q;
	logic ovf_r;

	assign cfg = dspma_cfg_s'(ctrl_r);
	// clears are asynchronous and per group so one group can be held at zero
	assign grst_n = {NGRP{presetn}} & ~aclr;

	function automatic logic [RW-1:0] x72(input logic [PW-1:0] p, input logic s);
		return {{(RW-PW){s & p[PW-1]}}, p};
	endfunction

	// register bus: zero wait states, error on unmapped offsets
	assign hit = (paddr == OFF_CTRL) || (paddr == OFF_RSAT) || (paddr == OFF_STAT) ||
		(paddr == OFF_RLO) || (paddr == OFF_RMID) || (paddr == OFF_RHI);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
			rsat_r <= RSAT_RST;
		end else if (psel && penable && pwrite) begin
			if (paddr == OFF_CTRL)
				ctrl_r <= pwdata[CTRL_W-1:0];
			if (paddr == OFF_RSAT)
				rsat_r <= pwdata[RSAT_W-1:0];
		end
	end

	// read data is captured in the setup cycle so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFF_CTRL: prdata <= 32'(ctrl_r);
				OFF_RSAT: prdata <= 32'(rsat_r);
				OFF_STAT: prdata <= 32'((32'(sa | sb) << STAT_SGN) | (32'(ovf_r) << STAT_OVF));
				OFF_RLO: prdata <= result[31:0];
				OFF_RMID: prdata <= result[63:32];
				OFF_RHI: prdata <= 32'(result[RW-1:64]);
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// input group: sign controls and operands, each optionally registered
	always_ff @(posedge pclk or negedge grst_n[GRP_IN]) begin
		if (!grst_n[GRP_IN]) begin
			sa_r <= 1'b0;
			sb_r <= 1'b0;
		end else if (clk_ena[GRP_IN]) begin
			sa_r <= dyn.sign_a;
			sb_r <= dyn.sign_b;
		end
	end

	always_ff @(posedge pclk or negedge grst_n[GRP_IN]) begin
		if (!grst_n[GRP_IN]) begin
			op_r <= '0;
		end else if (clk_ena[GRP_IN]) begin
			op_r <= opnd;
		end
	end

	assign sa = cfg.sreg_en ? sa_r : dyn.sign_a;
	assign sb = cfg.sreg_en ? sb_r : dyn.sign_b;
	assign op = cfg.ireg_en ? op_r : opnd;

	// wide modes: mult k takes a-half k[0] and b-half k[1]; low halves unsigned
	assign wide = (cfg.mode == M_M36) || (cfg.mode == M_DBL);
	assign mwa = wide ? NAT18 : cfg.wa;
	assign mwb = wide ? NAT18 : cfg.wb;

	always_comb begin
		for (int k = 0; k < NMUL; k++) begin
			msa[k] = sa;
			msb[k] = sb;
			if (cfg.mode == M_M36) begin
				msa[k] = sa & ((k & 1) != 0);
				msb[k] = sb & ((k & 2) != 0);
			end
			if (cfg.mode == M_DBL) begin
				msa[k] = 1'b0;
				msb[k] = 1'b0;
			end
		end
	end

	for (genvar g = 0; g < NMUL; g++) begin : g_mul
		// four products per half at any native size
		dspma_mult u_mul (
			.a(op[g].a),
			.b(op[g].b),
			.wa(mwa),
			.wb(mwb),
			.sa(msa[g]),
			.sb(msb[g]),
			.p(prod[g]),
			.psgn(psgn[g])
		);
	end

	// first-stage adders see nothing but the product pairs
	always_comb begin
		for (int j = 0; j < 2; j++) begin
			if ((j == 0) ? cfg.sub0 : cfg.sub1)
				s1[j] = dspma_px(prod[2*j], psgn[2*j]) - dspma_px(prod[2*j+1], psgn[2*j+1]);
			else
				s1[j] = dspma_px(prod[2*j], psgn[2*j]) + dspma_px(prod[2*j+1], psgn[2*j+1]);
		end
	end

	// pipeline group; the sign flags are not delayed, so signs must settle first
	always_ff @(posedge pclk or negedge grst_n[GRP_PIPE]) begin
		if (!grst_n[GRP_PIPE]) begin
			for (int k = 0; k < NMUL; k++)
				pp_r[k] <= '0;
			s1_r[0] <= '0;
			s1_r[1] <= '0;
		end else if (clk_ena[GRP_PIPE]) begin
			for (int k = 0; k < NMUL; k++)
				pp_r[k] <= prod[k];
			s1_r[0] <= s1[0];
			s1_r[1] <= s1[1];
		end
	end

	always_comb begin
		for (int k = 0; k < NMUL; k++)
			pq[k] = cfg.pipe_en ? pp_r[k] : prod[k];
		s1q[0] = cfg.pipe_en ? s1_r[0] : s1[0];
		s1q[1] = cfg.pipe_en ? s1_r[1] : s1[1];
	end

	// shift-and-add of the four partial products behind the pipeline
	assign m72 = (x72(pq[3], psgn[3]) << PW) +
		((x72(pq[1], psgn[1]) + x72(pq[2], psgn[2])) << DW) +
		x72(pq[0], psgn[0]);

	// second adder: inputs are only first-stage sums, products or own feedback
	always_comb begin
		case (cfg.mode)
			M_SUM4, M_CHAIN: s2 = dspma_x44(s1q[0]) + dspma_x44(s1q[1]);
			M_MAC: s2 = (dyn.acc_sload ? '0 : s2a_r) +
				dspma_x44(s1q[0]) + dspma_x44(s1q[1]);
			M_M36, M_DBL: s2 = m72[S2W-1:0];
			default: s2 = dspma_x44(s1q[0]);
		endcase
	end

	always_ff @(posedge pclk or negedge grst_n[GRP_S2]) begin
		if (!grst_n[GRP_S2])
			s2a_r <= '0;
		else if (clk_ena[GRP_S2])
			s2a_r <= s2;
	end

	assign csum = s2a_r + chain_in;

	// round/sat is dropped for the 9- and 12-bit independent sizes
	assign rs_ok = !((cfg.mode == M_IND) &&
		((dspma_native(cfg.wa) != NAT18) || (dspma_native(cfg.wb) != NAT18)));

	always_comb begin
		case (cfg.rsel)
			2'h0: rs_in = dspma_x44(dspma_px(prod[0], psgn[0]));
			2'h1: rs_in = dspma_x44(s1[0]);
			2'h2: rs_in = dspma_x44(s1q[0]);
			default: rs_in = (cfg.mode == M_CHAIN) ? csum : s2;
		endcase
	end

	dspma_rs u_rs (
		.x(rs_in),
		.rnd_en(dyn.round & rs_ok),
		.sat_en(dyn.saturate & rs_ok),
		.rnd_pos(rsat_r[5:0]),
		.sat_w(rsat_r[11:6]),
		.y(rs_y),
		.ovf(rs_ovf)
	);

	// output selector; steered from outside only when dynamic select is set
	assign osel = cfg.osel_dyn ? osel_dyn : cfg.osel;

	always_comb begin
		case (osel)
			O_MULT: omux = dspma_x44(dspma_px(prod[0], psgn[0]));
			O_S1: omux = dspma_x44(s1[0]);
			O_PIPE: omux = dspma_x44(s1q[0]);
			O_S2: omux = (cfg.mode == M_CHAIN) ? csum : s2;
			O_RS: omux = rs_y;
			default: omux = '0;
		endcase
	end

	assign ob_c = wide ? S2W'(m72[RW-1:S2W]) : omux;

	always_ff @(posedge pclk or negedge grst_n[GRP_OUT]) begin
		if (!grst_n[GRP_OUT]) begin
			ob_r <= '0;
			ovf_r <= 1'b0;
		end else if (clk_ena[GRP_OUT]) begin
			ob_r <= ob_c;
			ovf_r <= rs_ovf;
		end
	end

	// bypassing the banks trades a cycle of latency for a longer path
	assign ob_q = cfg.oreg_en ? ob_r : ob_c;
	assign lo_q = cfg.oreg_en ? s2a_r : s2;
	assign result = wide ? {ob_q[OHI_W-1:0], lo_q} :
		{{(RW-S2W){ob_q[S2W-1]}}, ob_q};
	assign chain_out = ob_r;
	assign sat_ovf = ovf_r;

	property p_prod_unsigned;
		@(posedge pclk) disable iff (!presetn)
		(cfg.mode == M_IND && !sa && !sb && cfg.wa == NAT18 && cfg.wb == NAT18)
			|-> (prod[0] == PW'({18'h0, op[0].a} * {18'h0, op[0].b}));
	endproperty
	a_prod_unsigned: assert property (p_prod_unsigned) else $error("unsigned product wrong");

	property p_prod_sign;
		@(posedge pclk) disable iff (!presetn)
		(cfg.mode == M_IND) |-> (psgn[1] == (sa | sb));
	endproperty
	a_prod_sign: assert property (p_prod_sign) else $error("product sign flag wrong");

	property p_pipe_delay;
		@(posedge pclk) disable iff (!presetn)
		(cfg.pipe_en && clk_ena[GRP_PIPE] && !aclr[GRP_PIPE]) ##1 $stable(cfg)
			|-> (s1q[0] == $past(s1[0]));
	endproperty
	a_pipe_delay: assert property (p_pipe_delay) else $error("pipeline not one cycle");

	property p_pipe_bypass;
		@(posedge pclk) disable iff (!presetn)
		!cfg.pipe_en |-> (s1q[1] == s1[1]);
	endproperty
	a_pipe_bypass: assert property (p_pipe_bypass) else $error("bypass not combinational");

	property p_out_hold;
		@(posedge pclk) disable iff (!presetn)
		(!clk_ena[GRP_OUT] && !aclr[GRP_OUT]) ##1 !aclr[GRP_OUT] |-> $stable(ob_r);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output bank moved while disabled");

	property p_out_clear;
		@(posedge pclk) disable iff (!presetn)
		aclr[GRP_OUT] |-> (ob_r == '0 && !sat_ovf);
	endproperty
	a_out_clear: assert property (p_out_clear) else $error("clear did not zero output bank");

	property p_chain_sum;
		@(posedge pclk) disable iff (!presetn)
		(cfg.mode == M_CHAIN && osel == O_S2 && clk_ena[GRP_OUT] && !aclr[GRP_OUT])
			##1 !aclr[GRP_OUT] |-> (chain_out == $past(csum));
	endproperty
	a_chain_sum: assert property (p_chain_sum) else $error("chain sum not registered");

	property p_rs_gate;
		@(posedge pclk) disable iff (!presetn)
		(cfg.mode == M_IND && dspma_native(cfg.wa) == NAT9) |-> !rs_ovf;
	endproperty
	a_rs_gate: assert property (p_rs_gate) else $error("round/sat active at 9-bit size");

	property p_wide_bank;
		@(posedge pclk) disable iff (!presetn)
		(wide && cfg.oreg_en) |-> (result == {ob_r[OHI_W-1:0], s2a_r});
	endproperty
	a_wide_bank: assert property (p_wide_bank) else $error("72-bit bank not combined");

	property p_slverr;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> (psel && penable && !hit);
	endproperty
	a_slverr: assert property (p_slverr) else $error("error outside bad access");

endmodule

/* File: dspma_mult.sv */
// one native multiplier: size pick, lsb padding, per-operand sign
`timescale 1ns/1ps
module dspma_mult import dspma_pkg::*; (
	input wire logic [DW-1:0] a,
	input wire logic [DW-1:0] b,
	input wire logic [4:0] wa,
	input wire logic [4:0] wb,
	input wire logic sa,
	input wire logic sb,
	output logic [PW-1:0] p,
	output logic psgn
);

	logic [DW:0] ea;
	logic [DW:0] eb;
	logic signed [2*DW+1:0] full;

	// pad at the lsb end up to the native size, then extend per sign
	function automatic logic [DW:0] prep(input logic [DW-1:0] d, input logic [4:0] w,
			input logic s);
		logic [4:0] wc;
		logic [4:0] n;
		logic [DW:0] r;
		wc = (w > NAT18) ? NAT18 : w;
		n = dspma_native(wc);
		r = {1'b0, d & ((18'h1 << wc) - 18'h1)};
		r = r << (n - wc);
		for (int i = 0; i <= DW; i++) begin
			if (i >= n)
				r[i] = s & r[n-1];
		end
		return r;
	endfunction

	assign ea = prep(a, wa, sa);
	assign eb = prep(b, wb, sb);
	// one extra bit per operand keeps every sign mix exact in 36 bits
	assign full = $signed(ea) * $signed(eb);
	assign p = full[PW-1:0];
	assign psgn = sa | sb;

endmodule

/* File: dspma_pkg.sv */
// package: constants, types and helpers for the multiply-add half block
package dspma_pkg;

	localparam int DW = 18;
	localparam int PW = 36;
	localparam int S1W = 38;
	localparam int S2W = 44;
	localparam int RW = 72;
	localparam int OHI_W = 28;
	localparam int NMUL = 4;
	localparam int NGRP = 4;

	localparam logic [4:0] NAT9 = 5'h09;
	localparam logic [4:0] NAT12 = 5'h0c;
	localparam logic [4:0] NAT18 = 5'h12;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RSAT = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_RLO = 8'h0c;
	localparam logic [7:0] OFF_RMID = 8'h10;
	localparam logic [7:0] OFF_RHI = 8'h14;

	localparam int CTRL_W = 25;
	localparam logic [24:0] CTRL_RST = 25'h0081290;
	localparam int RSAT_W = 12;
	localparam logic [11:0] RSAT_RST = 12'h911;
	localparam int STAT_OVF = 0;
	localparam int STAT_SGN = 1;

	localparam int GRP_IN = 0;
	localparam int GRP_PIPE = 1;
	localparam int GRP_S2 = 2;
	localparam int GRP_OUT = 3;

	typedef enum logic [2:0] {M_IND, M_SUM2, M_SUM4, M_MAC, M_M36, M_DBL, M_CHAIN} dspma_mode_e;
	typedef enum logic [2:0] {O_MULT, O_S1, O_PIPE, O_S2, O_RS} dspma_osel_e;

	// packed so that a cast of the control word lays the fields out in place
	typedef struct packed {
		logic ireg_en;
		logic sreg_en;
		logic osel_dyn;
		logic [1:0] rsel;
		logic oreg_en;
		dspma_osel_e osel;
		logic pipe_en;
		logic sub1;
		logic sub0;
		logic [4:0] wb;
		logic [4:0] wa;
		dspma_mode_e mode;
	} dspma_cfg_s;

	typedef struct packed {
		logic [DW-1:0] a;
		logic [DW-1:0] b;
	} dspma_opnd_s;

	typedef struct packed {
		logic sign_a;
		logic sign_b;
		logic round;
		logic saturate;
		logic acc_sload;
	} dspma_dyn_s;

	function automatic logic [4:0] dspma_native(input logic [4:0] w);
		if (w <= NAT9)
			return NAT9;
		if (w <= NAT12)
			return NAT12;
		return NAT18;
	endfunction

	function automatic logic [S1W-1:0] dspma_px(input logic [PW-1:0] p, input logic s);
		return {{(S1W-PW){s & p[PW-1]}}, p};
	endfunction

	function automatic logic [S2W-1:0] dspma_x44(input logic [S1W-1:0] v);
		return {{(S2W-S1W){v[S1W-1]}}, v};
	endfunction

endpackage

/* File: dspma_rs.sv */
// round then saturate on a 44-bit value
`timescale 1ns/1ps
module dspma_rs import dspma_pkg::*; (
	input wire logic [S2W-1:0] x,
	input wire logic rnd_en,
	input wire logic sat_en,
	input wire logic [5:0] rnd_pos,
	input wire logic [5:0] sat_w,
	output logic [S2W-1:0] y,
	output logic ovf
);

	logic signed [S2W:0] rx;
	logic signed [S2W:0] hi;
	logic signed [S2W:0] lo;

	always_comb begin
		rx = {x[S2W-1], x};
		if (rnd_en && rnd_pos != 6'h00) begin
			rx = rx + (45'sh1 <<< (rnd_pos - 6'h01));
			rx = rx & ~((45'sh1 <<< rnd_pos) - 45'sh1);
		end
		hi = (45'sh1 <<< (sat_w - 6'h01)) - 45'sh1;
		lo = -(45'sh1 <<< (sat_w - 6'h01));
		y = rx[S2W-1:0];
		ovf = 1'b0;
		if (sat_en && sat_w != 6'h00) begin
			if (rx > hi) begin
				y = hi[S2W-1:0];
				ovf = 1'b1;
			end else if (rx < lo) begin
				y = lo[S2W-1:0];
				ovf = 1'b1;
			end
		end
	end

endmodule

/* File: tb_dspma_half.sv */
// self-checking bench for the multiply-add half block
`timescale 1ns/1ps
module tb_dspma_half import dspma_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [NGRP-1:0] clk_ena = 4'hf;
	logic [NGRP-1:0] aclr = 4'h0;
	dspma_opnd_s [NMUL-1:0] opnd;
	dspma_dyn_s dyn;
	dspma_osel_e osel_dyn = O_MULT;
	logic [S2W-1:0] chain_in;
	logic [S2W-1:0] chain_out;
	logic [RW-1:0] result;
	logic sat_ovf;
	logic [31:0] rd;
	logic rerr;
	logic inreg = 1'b0;
	logic [RW-1:0] e;
	int err_count = 0;
	int compares = 0;
	int wt[5] = '{9, 10, 12, 13, 18};
	logic [S2W-1:0] rs_exp[4] = '{44'h45, 44'h1f, 44'h40, 44'h1f};

	always #5 pclk = ~pclk;

	dspma_half dspma_half_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clk_ena(clk_ena), .aclr(aclr), .opnd(opnd), .dyn(dyn),
		.osel_dyn(osel_dyn), .chain_in(chain_in), .chain_out(chain_out), .result(result),
		.sat_ovf(sat_ovf));

	dspma_fabric dspma_fabric_i(.pclk(pclk), .presetn(presetn), .opnd(opnd), .dyn(dyn),
		.chain_in(chain_in));

	task automatic check(input string what, input logic [RW-1:0] seen, input logic [RW-1:0] x);
		compares++;
		if (seen !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, x, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string what);
		apb(1'b0, a, 32'h0);
		check(what, rd, x);
	endtask

	task automatic setcfg(input dspma_mode_e m, input logic [4:0] w, input logic sb0,
		input logic pe, input dspma_osel_e os, input logic oe, input logic [1:0] rs,
		input logic od);
		dspma_cfg_s c;
		c = '{inreg, inreg, od, rs, oe, os, pe, 1'b0, sb0, w, w, m};
		apb(1'b1, OFF_CTRL, {7'h0, c});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	function automatic int nat(input int w);
		return w <= 9 ? 9 : (w <= 12 ? 12 : 18);
	endfunction

	function automatic logic signed [37:0] ext(input logic [17:0] v, input logic s);
		return s ? {{20{v[17]}}, v} : {20'h0, v};
	endfunction

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check("result", result, '0);
		check("chain_out", chain_out, '0);
		rd_chk(OFF_CTRL, {7'h0, CTRL_RST}, "ctrl");
		rd_chk(OFF_RSAT, {20'h0, RSAT_RST}, "rsat");
		rd_chk(OFF_RLO, 32'h0, "rlo");
		// unmapped write must be refused and leave the control word alone
		apb(1'b1, 8'h18, 32'hffffffff);
		check("slverr", rerr, 1'b1);
		rd_chk(OFF_CTRL, {7'h0, CTRL_RST}, "ctrl kept");
		setcfg(M_SUM2, 5'h12, 1'b0, 1'b0, O_S1, 1'b0, 2'h0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			dspma_fabric_i.ctl(i[1], i[0], 1'b0, 1'b0, '0);
			dspma_fabric_i.ops(0, 18'h3fffd, 18'h3fffb);
			settle(2);
			e = ext(18'h3fffd, i[1]) * ext(18'h3fffb, i[0]);
			check("signed product", result[37:0], e[37:0]);
			apb(1'b0, OFF_STAT, 32'h0);
			check("stat sign", rd[STAT_SGN], i[1] | i[0]);
		end
		dspma_fabric_i.ctl(1'b0, 1'b0, 1'b0, 1'b0, '0);
		dspma_fabric_i.ops(0, 18'h3, 18'h5);
		foreach (wt[j]) begin
			setcfg(M_SUM2, 5'(wt[j]), 1'b0, 1'b0, O_S1, 1'b0, 2'h0, 1'b0);
			settle(2);
			e = 72'hf << (2 * (nat(wt[j]) - wt[j]));
			check("padded product", result[37:0], e[37:0]);
		end
		setcfg(M_SUM4, 5'h12, 1'b1, 1'b1, O_S2, 1'b1, 2'h0, 1'b0);
		aclr <= 4'hf;
		dspma_fabric_i.ops(0, 18'h7, 18'h3);
		dspma_fabric_i.ops(1, 18'h2, 18'h4);
		dspma_fabric_i.ops(2, 18'h5, 18'h5);
		dspma_fabric_i.ops(3, 18'h1, 18'h6);
		@(posedge pclk);
		aclr <= 4'h0;
		settle(1);
		check("pipe stage", result, '0);
		settle(0);
		settle(1);
		check("four sum", result[43:0], 44'h2c);
		check("chain_out", chain_out, 44'h2c);
		@(posedge pclk);
		clk_ena <= 4'h7;
		dspma_fabric_i.ops(0, 18'h9, 18'h7);
		settle(3);
		check("held bank", result[43:0], 44'h2c);
		@(posedge pclk);
		aclr <= 4'h8;
		@(negedge pclk);
		check("cleared bank", result[43:0], 44'h0);
		@(posedge pclk);
		aclr <= 4'h0;
		clk_ena <= 4'hf;
		// the preceding block hands over minus one
		setcfg(M_CHAIN, 5'h12, 1'b0, 1'b1, O_S2, 1'b1, 2'h0, 1'b0);
		dspma_fabric_i.ctl(1'b0, 1'b0, 1'b0, 1'b0, '1);
		settle(6);
		check("chain sum", result[43:0], 44'h65);
		check("chain_out", chain_out, 44'h65);
		// equal halves keep the check free of the operand-to-multiplier mapping
		for (int m = 0; m < 2; m++) begin
			setcfg(m ? M_DBL : M_M36, 5'h12, 1'b0, 1'b1, O_S2, 1'b1, 2'h0, 1'b0);
			dspma_fabric_i.ctl(m[0], m[0], 1'b0, 1'b0, '0);
			for (int k = 0; k < NMUL; k++)
				dspma_fabric_i.ops(k, 18'h3ffff, 18'h3ffff);
			settle(6);
			e = 72'hfffffffff * 72'hfffffffff;
			check("wide product", result, e);
			rd_chk(OFF_RLO, e[31:0], "rlo");
			rd_chk(OFF_RMID, e[63:32], "rmid");
			rd_chk(OFF_RHI, {24'h0, e[71:64]}, "rhi");
		end
		setcfg(M_SUM2, 5'h12, 1'b0, 1'b0, O_MULT, 1'b0, 2'h1, 1'b1);
		apb(1'b1, OFF_RSAT, 32'h184);
		for (int k = 1; k < NMUL; k++)
			dspma_fabric_i.ops(k, 18'h0, 18'h0);
		dspma_fabric_i.ops(0, 18'h17, 18'h3);
		osel_dyn <= O_RS;
		for (int i = 0; i < 4; i++) begin
			dspma_fabric_i.ctl(1'b0, 1'b0, i[1], i[0], '0);
			settle(2);
			check("round sat", result[43:0], rs_exp[i]);
			check("sat_ovf", sat_ovf, i[0]);
			apb(1'b0, OFF_STAT, 32'h0);
			check("stat ovf", rd[STAT_OVF], i[0]);
		end
		osel_dyn <= O_S1;
		settle(1);
		check("dynamic select", result[37:0], 38'h45);
		// independent mode: round/sat must stay off below the 18-bit size
		for (int m = 0; m < 2; m++) begin
			setcfg(M_IND, m ? 5'h12 : 5'h09, 1'b0, 1'b0, O_RS, 1'b0, 2'h0, 1'b0);
			dspma_fabric_i.ctl(1'b0, 1'b0, 1'b1, 1'b1, '0);
			settle(2);
			check("ind round sat", result[43:0], m ? 44'h1f : 44'h45);
			check("ind sat_ovf", sat_ovf, m[0]);
		end
		// registered signs and operands lag the fabric by one edge
		inreg = 1'b1;
		setcfg(M_IND, 5'h12, 1'b0, 1'b0, O_MULT, 1'b0, 2'h0, 1'b0);
		dspma_fabric_i.ctl(1'b0, 1'b1, 1'b0, 1'b0, '0);
		dspma_fabric_i.ops(0, 18'h2, 18'h3fffd);
		settle(0);
		check("registered inputs", result[43:0], 44'h45);
		settle(1);
		check("registered inputs", result, 72'hfffffffffffffffffa);
		// accumulate: hold the load for three edges, then add the same product on every edge
		inreg = 1'b0;
		setcfg(M_MAC, 5'h12, 1'b0, 1'b0, O_S2, 1'b1, 2'h0, 1'b0);
		dspma_fabric_i.ops(0, 18'h2, 18'h3);
		dspma_fabric_i.acc(1'b1);
		settle(2);
		check("acc load", result[43:0], 44'h6);
		@(posedge pclk);
		dspma_fabric_i.acc(1'b0);
		settle(3);
		check("accumulate", result[43:0], 44'h18);
		test_done();
	end

	// whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		test_done();
	end
endmodule
